// >>> hw/rbx_map.svh
// Purpose: Constants for the 10 Mbps backplane collision and expansion block
// Assumes: 200 MHz system clock
// Notes: Times are in their own units; cycle counts derive from them
`ifndef RBX_MAP_SVH
`define RBX_MAP_SVH

`define RBX_CLK_MHZ 200
`define RBX_HOLD_NS 1000
`define RBX_INDEX_PRIMARY 2'h0
`define RBX_INDEX_W 2
`define RBX_HOLD_CNT_W 16
`define RBX_SYNC_W 10
`define RBX_SYNC_FILL 2'h2

`endif

// >>> hw/rbx_pkg.sv
// Purpose: Types for the 10 Mbps backplane collision and expansion block
// Assumes: rbx_map.svh holds the numbers
// Notes: Pin groups travel as packed structs
package rbx_pkg;
   `include "rbx_map.svh"

   typedef struct packed {
      logic recovered_clock;
      logic carrier_n;
      logic board_collision_n;
      logic collision_hold;
      logic external_mac_join;
      logic mgmt_chain;
      logic force_sense_n;
      logic serial_data;
      logic [`RBX_INDEX_W-1:0] index;
   } rbx_pins_t;

   typedef struct packed {
      logic carrier_n;
      logic board_collision_n;
      logic backplane_collision_n;
      logic force_sense;
      logic backplane_force_sense;
      logic collision_hold;
      logic serial_data;
   } rbx_drive_t;

   typedef enum logic [1:0] {
      RBX_MAC_IDLE,
      RBX_MAC_ARMED,
      RBX_MAC_ACTIVE
   } rbx_mac_t;

   typedef struct packed {
      logic strap_done;
      logic [1:0] warm;
      logic [`RBX_INDEX_W-1:0] index;
      logic clk_d;
      rbx_mac_t mac;
      logic [`RBX_HOLD_CNT_W-1:0] hold_cnt;
      logic coll_d;
      logic count_pulse;
      logic chain_out;
      logic rx_data;
      logic rx_valid;
      logic tx_bit;
      rbx_drive_t oe_n;
      logic [1:0] fs_hist;
      logic isolate;
   } rbx_state_t;
endpackage

// >>> hw/rbx_sync.sv
// Purpose: Two flip-flop synchroniser for pins outside the clock domain
// Assumes: Inputs are static levels or slow compared to the clock
// Notes: The first stage is read only by the second stage
`timescale 1ns/1ps
module rbx_sync #(
   parameter int WIDTH = 1
) (
   // Clock, reset and enable
   input wire logic sys_clk_in,
   input wire logic sys_rst_in,
   input wire logic ce_in,
   // Data
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;

   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         stage1 <= '0;
         sync_out <= '0;
      end else if (ce_in) begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end
endmodule

// >>> hw/rbx_expansion.sv
// Purpose: Collision signalling and expansion control, 10 Mbps backplane
// Assumes: Local repeater core inputs share sys_clk_in; pins are async
// Notes: Open-drain pins use value plus active-low output enable
`timescale 1ns/1ps
`include "rbx_map.svh"
// Function
// - Index 00 mirrors board collision onto backplane
// - Pull force sense low on transmit collision
// - Index 0 drives backplane copy of force sense
// - Repeater drives force sense for joined MAC
// - Isolate high disables transceiver, low enables
// - Index 00 drives hold for non-local collisions
// - Chain input comes from previous chain output
// - Pull board collision low on segment collision
// - Carrier low shows backplane activity
// - Serial data moves on recovered clock rising
module rbx_expansion #(
   parameter int HOLD_CYCLES =
      (`RBX_HOLD_NS * `RBX_CLK_MHZ + 999) / 1000
) (
   // Clock, reset and enable
   input wire logic sys_clk_in,
   input wire logic sys_rst_in,
   input wire logic ce_in,
   // Local repeater core
   input wire logic local_tx_active_in,
   input wire logic local_tx_data_in,
   input wire logic local_tx_collision_in,
   input wire logic segment_collision_in,
   input wire logic backplane_enable_in,
   // Backplane pins, input side
   input wire rbx_pkg::rbx_pins_t pins_in,
   // Backplane pins, output side
   output rbx_pkg::rbx_drive_t drive_out,
   output rbx_pkg::rbx_drive_t drive_oe_n_out,
   output logic backplane_isolate_out,
   output logic mgmt_chain_out,
   // Status to the core
   output logic counting_role_out,
   output logic collision_count_out,
   output logic mac_session_out,
   output logic rx_data_out,
   output logic rx_valid_out
);
   import rbx_pkg::*;

   localparam logic [`RBX_HOLD_CNT_W-1:0] HOLD_LOAD =
      `RBX_HOLD_CNT_W'(HOLD_CYCLES);

   rbx_state_t state;
   rbx_state_t next_state;
   rbx_pins_t pins_s;
   logic clk_rise;
   logic primary;
   logic mac_tx;
   logic tx_collision;
   logic remote_collision;
   logic board_coll;
   logic role;
   // Decode helpers
   logic own_echo;
   logic hold_active;
   logic local_carrier;

   // Pin synchronisers
   rbx_sync #(
      .WIDTH(`RBX_SYNC_W)
   ) u_sync (
      .sys_clk_in(sys_clk_in),
      .sys_rst_in(sys_rst_in),
      .ce_in(ce_in),
      .async_in(pins_in),
      .sync_out(pins_s)
   );

   // Next-state logic
   always_comb begin
      next_state = state;
      // Edge and role decode
      clk_rise = pins_s.recovered_clock & ~state.clk_d;
      primary = state.strap_done & (state.index == `RBX_INDEX_PRIMARY);
      role = ~pins_s.mgmt_chain;
      next_state.clk_d = pins_s.recovered_clock;

      // Strap capture once the synchronisers hold real pin levels
      if (!state.strap_done) begin
         if (state.warm == `RBX_SYNC_FILL) begin
            next_state.index = pins_s.index;
            next_state.strap_done = 1'b1;
         end else begin
            next_state.warm = state.warm + 2'h1;
         end
      end

      // MAC join tracking; join and carrier start taken on recovered clock edges, session ends on any cycle with carrier high
      unique case (state.mac)
         RBX_MAC_IDLE: begin
            if (clk_rise && pins_s.external_mac_join) begin
               next_state.mac = RBX_MAC_ARMED;
            end
         end
         RBX_MAC_ARMED: begin
            if (clk_rise && !pins_s.carrier_n) begin
               next_state.mac = RBX_MAC_ACTIVE;
            end
         end
         RBX_MAC_ACTIVE: begin
            if (pins_s.carrier_n) begin
               next_state.mac = RBX_MAC_IDLE;
            end
         end
         // Unused encoding falls back to idle
         default: begin
            next_state.mac = RBX_MAC_IDLE;
         end
      endcase
      mac_tx = (state.mac == RBX_MAC_ACTIVE);
      local_carrier = local_tx_active_in & ~mac_tx;

      // Transmit collision: local, or joined MAC against our transmit
      tx_collision = local_tx_collision_in |
                     (mac_tx & local_tx_active_in);
      // Own drive echoes back through the synchroniser for two cycles
      next_state.fs_hist = {state.fs_hist[0], state.oe_n.force_sense};
      own_echo = ~state.oe_n.force_sense | ~state.fs_hist[0] |
                 ~state.fs_hist[1];
      remote_collision = ~pins_s.force_sense_n & ~own_echo;

      // Collision hold stretch
      hold_active = (state.hold_cnt != '0);
      if (primary && remote_collision) begin
         next_state.hold_cnt = HOLD_LOAD;
      end else if (hold_active) begin
         next_state.hold_cnt = state.hold_cnt - 1'b1;
      end

      board_coll = segment_collision_in | tx_collision | hold_active |
                   (~primary & pins_s.collision_hold);

      // Open-drain enables, low while driving
      next_state.oe_n.board_collision_n = ~board_coll;
      next_state.oe_n.backplane_collision_n =
         ~(board_coll & primary);
      next_state.oe_n.force_sense = ~tx_collision;
      next_state.oe_n.backplane_force_sense =
         ~(tx_collision & primary);
      next_state.oe_n.collision_hold =
         ~(primary & (next_state.hold_cnt != '0));
      next_state.oe_n.carrier_n = ~local_carrier;

      // Serial data driven and sampled on recovered clock rise
      next_state.rx_valid = 1'b0;
      if (clk_rise) begin
         next_state.tx_bit = local_tx_data_in;
         if (!pins_s.carrier_n) begin
            next_state.rx_data = pins_s.serial_data;
            next_state.rx_valid = 1'b1;
         end
      end
      next_state.oe_n.serial_data =
         ~(local_carrier & ~next_state.tx_bit);

      // One count per collision by the chain head
      next_state.coll_d = board_coll;
      next_state.count_pulse = role & board_coll & ~state.coll_d;
      next_state.chain_out = state.strap_done;

      // Transceiver isolate
      next_state.isolate = ~(primary & backplane_enable_in);
   end

   // State register
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         state <= '{
            strap_done: 1'b0,
            warm: 2'h0,
            index: '0,
            clk_d: 1'b0,
            mac: RBX_MAC_IDLE,
            hold_cnt: '0,
            coll_d: 1'b0,
            count_pulse: 1'b0,
            chain_out: 1'b0,
            rx_data: 1'b0,
            rx_valid: 1'b0,
            tx_bit: 1'b1,
            oe_n: '1,
            fs_hist: 2'h3,
            isolate: 1'b1
         };
      // Freeze all state while the clock enable is low
      end else if (ce_in) begin
         state <= next_state;
      end
   end

   // Open-drain value levels; enables decide the wire
   assign drive_out = '{
      carrier_n: 1'b0,
      board_collision_n: 1'b0,
      backplane_collision_n: 1'b0,
      force_sense: 1'b0,
      backplane_force_sense: 1'b0,
      collision_hold: 1'b1,
      serial_data: 1'b0
   };
   // Pin enable and status outputs
   assign drive_oe_n_out = state.oe_n;
   assign backplane_isolate_out = state.isolate;
   assign mgmt_chain_out = state.chain_out;
   assign counting_role_out = ~pins_s.mgmt_chain;
   assign collision_count_out = state.count_pulse;
   assign mac_session_out = (state.mac == RBX_MAC_ACTIVE);
   assign rx_data_out = state.rx_data;
   assign rx_valid_out = state.rx_valid;
endmodule

// >>> test/rbx_expansion_props.sv
// Purpose: Port checks for rbx_expansion
// Assumes: Bound to the design top, strap index 0
// Notes: Bench runs with a short hold count
`timescale 1ns/1ps
module rbx_expansion_props import rbx_pkg::*; #(
   parameter int HOLD_CYCLES = 8
) (
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic sys_rst_in,
   // Core side
   input wire logic segment_collision_in,
   input wire logic backplane_enable_in,
   // Pins and status
   input wire rbx_pkg::rbx_pins_t pins_in,
   input wire rbx_pkg::rbx_drive_t drive_oe_n_out,
   input wire logic backplane_isolate_out,
   input wire logic mgmt_chain_out,
   input wire logic counting_role_out,
   input wire logic collision_count_out,
   input wire logic rx_valid_out
);
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (sys_rst_in);
   int hold_run;
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in || drive_oe_n_out.collision_hold) begin
         hold_run <= 0;
      end else begin
         hold_run <= hold_run + 1;
      end
   end
   property p_hold_len;
      $rose(drive_oe_n_out.collision_hold) |-> hold_run >= HOLD_CYCLES;
   endproperty
   sequence s_idle; pins_in.carrier_n [*8]; endsequence
   sequence s_hold; !drive_oe_n_out.collision_hold [*6]; endsequence
   property p_coll;
      segment_collision_in |=> !drive_oe_n_out.board_collision_n;
   endproperty
   property p_bpcoll;
      !drive_oe_n_out.backplane_collision_n |->
         !drive_oe_n_out.board_collision_n;
   endproperty
   property p_bpfs;
      !drive_oe_n_out.backplane_force_sense |-> !drive_oe_n_out.force_sense;
   endproperty
   property p_iso;
      !backplane_isolate_out |-> $past(backplane_enable_in);
   endproperty
   property p_cnt;
      collision_count_out |-> counting_role_out ##1 !collision_count_out;
   endproperty
   property p_rx; s_idle |=> !rx_valid_out; endproperty
   property p_chain; mgmt_chain_out |=> mgmt_chain_out; endproperty
   property p_hold; $fell(drive_oe_n_out.collision_hold) |-> s_hold;
   endproperty
   a_coll: assert property (p_coll) else $error("no collision");
   a_bpcoll: assert property (p_bpcoll) else $error("bp coll");
   a_bpfs: assert property (p_bpfs) else $error("bp force");
   a_iso: assert property (p_iso) else $error("isolate");
   a_cnt: assert property (p_cnt) else $error("count pulse");
   a_rx: assert property (p_rx) else $error("rx idle");
   a_chain: assert property (p_chain) else $error("chain");
   a_hold: assert property (p_hold) else $error("hold short");
   a_hold_len: assert property (p_hold_len) else $error("hold len");
endmodule

// >>> test/rbx_mac_model.sv
// Purpose: External MAC on the 10 Mbps backplane
// Assumes: Link clock stands low between frames
// Notes: Released data shows its pull-up level
`timescale 1ns/1ps
module rbx_mac_model (
   // Pins driven by the MAC
   output logic link_clk_out,
   output logic carrier_n_out,
   output logic join_out,
   output logic data_out,
   // Collision seen during a frame
   output logic collision_seen_out,
   // Pin watched by the MAC
   input wire logic board_collision_n_in
);
   initial begin
      collision_seen_out = 1'b0;
      link_clk_out = 1'b0;
      carrier_n_out = 1'b1;
      join_out = 1'b0;
      data_out = 1'b1;
   end
   task automatic tick();
      #80 link_clk_out = 1'b1;
      // Collision watch while carrier is held low
      if (!carrier_n_out && !board_collision_n_in) begin
         collision_seen_out = 1'b1;
      end
      #80 link_clk_out = 1'b0;
   endtask
   // Join for one clock, then carrier low
   task automatic frame(input int nbits);
      int i;
      collision_seen_out = 1'b0;
      join_out = 1'b1;
      tick();
      join_out = 1'b0;
      carrier_n_out = 1'b0;
      // Bits change away from the rising edge
      for (i = 0; i < nbits; i++) begin
         data_out = i[0];
         tick();
      end
      carrier_n_out = 1'b1;
      data_out = 1'b1;
   endtask
endmodule

// >>> test/rbx_expansion_tb_top.sv
// Purpose: Self-checking bench for rbx_expansion
// Assumes: Strap index 0, chain input grounded
// Notes: Wire levels come from all enables but the two backplane copies
`timescale 1ns/1ps
module rbx_expansion_tb_top;
   import rbx_pkg::*;
   logic sys_clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic local_tx_active_in = 1'b0, local_tx_collision_in = 1'b0;
   logic segment_collision_in = 1'b0, backplane_enable_in = 1'b0;
   logic ext_fs = 1'b0;
   logic iso, chain, role, cnt_p, sess, rx_v, rx_d;
   logic lclk, lcar_n, ljoin, ldat, lseen;
   logic [3:0] rx_word = 4'h0;
   rbx_pins_t pins;
   rbx_drive_t oe_n, dv;
   int mismatches = 0, total_checks = 0, pulses = 0, bits = 0;
   always #2.5 sys_clk_in = ~sys_clk_in;
   always @(posedge sys_clk_in) begin
      pulses <= pulses + int'(cnt_p === 1'b1);
      bits <= bits + int'(rx_v === 1'b1);
      if (rx_v === 1'b1) begin
         rx_word <= {rx_word[2:0], rx_d};
      end
   end
   assign pins = '{recovered_clock: lclk, carrier_n: lcar_n & oe_n.carrier_n,
      board_collision_n: oe_n.board_collision_n,
      collision_hold: ~oe_n.collision_hold, external_mac_join: ljoin,
      mgmt_chain: 1'b0, force_sense_n: oe_n.force_sense & ~ext_fs,
      serial_data: ldat & oe_n.serial_data, index: 2'h0};
   rbx_expansion #(.HOLD_CYCLES(8)) rbx_expansion_i (.sys_clk_in,
      .sys_rst_in, .ce_in(1'b1), .local_tx_active_in, .local_tx_data_in(1'b0),
      .local_tx_collision_in, .segment_collision_in, .backplane_enable_in,
      .pins_in(pins), .drive_out(dv), .drive_oe_n_out(oe_n),
      .backplane_isolate_out(iso), .mgmt_chain_out(chain),
      .counting_role_out(role), .collision_count_out(cnt_p),
      .mac_session_out(sess), .rx_data_out(rx_d), .rx_valid_out(rx_v));
   rbx_mac_model rbx_mac_model_i (.link_clk_out(lclk), .carrier_n_out(lcar_n),
      .join_out(ljoin), .data_out(ldat), .collision_seen_out(lseen),
      .board_collision_n_in(oe_n.board_collision_n));
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk_in);
      #1;
   endtask
   task automatic chk(input logic got, input logic exp, input string what);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t %s", $time, what);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic t_hold();
      ext_fs = 1'b1;
      cyc(2);
      ext_fs = 1'b0;
      cyc(3);
      chk(oe_n.collision_hold, 1'b0, "no hold");
      chk(oe_n.board_collision_n, 1'b0, "no board coll");
      cyc(12);
      chk(oe_n.collision_hold, 1'b1, "hold stuck");
      $display("done hold");
   endtask
   task automatic t_mac();
      int k, n;
      n = bits;
      fork rbx_mac_model_i.frame(4); join_none
      for (k = 0; k < 400 && sess !== 1'b1; k++) cyc(1);
      chk(sess, 1'b1, "no session");
      local_tx_active_in = 1'b1;
      cyc(2);
      chk(oe_n.force_sense, 1'b0, "mac force");
      chk(oe_n.carrier_n, 1'b1, "carrier taken");
      for (k = 0; k < 800 && lcar_n !== 1'b1; k++) cyc(1);
      local_tx_active_in = 1'b0;
      cyc(6);
      chk(sess, 1'b0, "session stuck");
      chk(bits - n == 4, 1'b1, "bit count");
      chk(rx_word == 4'h5, 1'b1, "bit values");
      chk(lseen, 1'b1, "mac saw no coll");
      $display("done mac");
   endtask
   task automatic t_reset();
      cyc(12);
      chk(&oe_n && iso && !chain, 1'b1, "reset drive");
      chk(dv == 7'h02, 1'b1, "drive levels");
      sys_rst_in = 1'b0;
      cyc(6);
      chk(chain & role, 1'b1, "chain");
      $display("done reset");
   endtask
   task automatic t_iso();
      backplane_enable_in = 1'b1;
      cyc(4);
      chk(iso, 1'b0, "not enabled");
      backplane_enable_in = 1'b0;
      cyc(4);
      chk(iso, 1'b1, "not isolated");
      $display("done isolate");
   endtask
   task automatic t_coll();
      int n;
      n = pulses;
      segment_collision_in = 1'b1;
      cyc(2);
      chk(oe_n.board_collision_n, 1'b0, "board coll");
      chk(oe_n.backplane_collision_n, 1'b0, "bp coll");
      chk(pulses - n == 1, 1'b1, "count");
      segment_collision_in = 1'b0;
      cyc(20);
      chk(oe_n.board_collision_n, 1'b1, "board coll stuck");
      $display("done coll");
   endtask
   task automatic t_tx();
      local_tx_collision_in = 1'b1;
      local_tx_active_in = 1'b1;
      cyc(4);
      chk(oe_n.force_sense, 1'b0, "tx coll");
      chk(oe_n.backplane_force_sense, 1'b0, "bp force");
      chk(oe_n.carrier_n, 1'b0, "no carrier");
      local_tx_collision_in = 1'b0;
      local_tx_active_in = 1'b0;
      cyc(4);
      chk(oe_n.collision_hold, 1'b1, "self hold");
      cyc(26);
      chk(oe_n.force_sense, 1'b1, "force stuck");
      chk(oe_n.carrier_n, 1'b1, "carrier stuck");
      $display("done tx");
   endtask
   initial begin
      t_reset();
      t_iso();
      t_coll();
      t_hold();
      t_tx();
      t_mac();
      end_of_test();
   end
   initial begin
      #20000;
      mismatches++;
      end_of_test();
   end
endmodule
bind rbx_expansion rbx_expansion_props #(.HOLD_CYCLES(HOLD_CYCLES))
   rbx_expansion_props_i (.sys_clk_in, .sys_rst_in, .segment_collision_in,
   .backplane_enable_in, .pins_in, .drive_oe_n_out, .backplane_isolate_out,
   .mgmt_chain_out, .counting_role_out, .collision_count_out, .rx_valid_out);
